//--- verilog/ucr_consts.svh
// Purpose : Named constants for the serial character responder
// Assumes : Included by bare name from the package file only
// Notes   : Definitions only
`ifndef UCR_CONSTS_SVH
`define UCR_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UCR_CLK_HZ        250000000
`define UCR_PERIPH_HZ     24000000
`define UCR_BAUD          9600
`define UCR_DATA_BITS     8

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define UCR_OFS_CTRL      4'h0
`define UCR_OFS_STATUS    4'h4
`define UCR_OFS_RXDATA    4'h8
`define UCR_CTRL_START    0
`define UCR_CTRL_HIPRIO   1
`define UCR_ST_RUN        0
`define UCR_ST_BUSY       1
`define UCR_ST_FULL       2
`define UCR_ST_PE         8
`define UCR_ST_FE         9
`define UCR_ST_OE         10

// ----------------------------------------------------------------
// Event levels
// ----------------------------------------------------------------
`define UCR_LVL_NONE      2'h0
`define UCR_LVL_ONE       2'h1
`define UCR_LVL_TWO       2'h2
`define UCR_LVL_TX        2'h3

// ----------------------------------------------------------------
// Characters
// ----------------------------------------------------------------
`define UCR_CH_UPPER_T    8'h54
`define UCR_CH_LOWER_T    8'h74
`define UCR_CH_O          8'h4F
`define UCR_CH_K          8'h4B
`define UCR_CH_LO         8'h6F
`define UCR_CH_LK         8'h6B
`define UCR_CH_U          8'h55
`define UCR_CH_C          8'h43
`define UCR_CH_P          8'h50
`define UCR_CH_E          8'h45
`define UCR_CH_F          8'h46
`define UCR_CH_CR         8'h0D
`define UCR_CH_LF         8'h0A
`define UCR_LAST_IDX      2'h3

`endif

//--- verilog/ucr_pkg.sv
// Purpose : Types shared by the serial character responder
// Assumes : Constants come from ucr_consts.svh
// Notes   : Types only
`include "ucr_consts.svh"

package ucr_pkg;

    // Receiver and transmitter sequencing
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ucr_rx_state_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucr_tx_state_t;

    // Reply selection
    typedef enum logic [2:0] {REP_UPPER, REP_LOWER, REP_OTHER, REP_PE, REP_FE, REP_OE} ucr_reply_t;

    // One received frame
    typedef struct packed {
        logic [7:0] data;
        logic       perr;
        logic       ferr;
    } ucr_rx_frame_t;

endpackage

//--- verilog/ucr_responder.sv
// Purpose : Serial responder giving a four-byte reply to each buffered character and to each pending overrun
// Assumes : Single 250 MHz clock, synchronous active-high reset
// Notes   : Control and status over classic Wishbone
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps

module ucr_responder
    import ucr_pkg::*;
#(
    parameter int unsigned CLK_HZ    = `UCR_CLK_HZ,
    parameter int unsigned PERIPH_HZ = `UCR_PERIPH_HZ,
    parameter int unsigned BIT_TICKS = `UCR_PERIPH_HZ / `UCR_BAUD
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Serial lines
    input  wire logic        serial_in_line_i,
    output logic             serial_out_line_o,
    // Events
    output logic             rx_done_event_o,
    output logic             tx_done_event_o,
    output logic             rx_error_event_o,
    output logic      [1:0]  event_level_o
);

    localparam logic [11:0] TICK_LAST = 12'(BIT_TICKS - 1);
    localparam logic [11:0] TICK_HALF = 12'(BIT_TICKS / 2);
    localparam logic [2:0]  BIT_LAST  = 3'(`UCR_DATA_BITS - 1);
    localparam logic [31:0] ACC_STEP  = 32'(PERIPH_HZ);
    localparam logic [31:0] ACC_WRAP  = 32'(CLK_HZ);

    // Reply byte lookup, shared by the transmitter
    function automatic logic [7:0] reply_byte(input ucr_reply_t kind, input logic [1:0] idx);
        logic [7:0] first;
        logic [7:0] second;
        first  = `UCR_CH_U;
        second = `UCR_CH_C;
        case (kind)
            REP_UPPER: begin
                first  = `UCR_CH_O;
                second = `UCR_CH_K;
            end
            REP_LOWER: begin
                first  = `UCR_CH_LO;
                second = `UCR_CH_LK;
            end
            REP_PE: begin
                first  = `UCR_CH_P;
                second = `UCR_CH_E;
            end
            REP_FE: begin
                first  = `UCR_CH_F;
                second = `UCR_CH_E;
            end
            REP_OE: begin
                first  = `UCR_CH_O;
                second = `UCR_CH_E;
            end
            default: begin
                first  = `UCR_CH_U;
                second = `UCR_CH_C;
            end
        endcase
        case (idx)
            2'h0:    reply_byte = first;
            2'h1:    reply_byte = second;
            2'h2:    reply_byte = `UCR_CH_CR;
            default: reply_byte = `UCR_CH_LF;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Peripheral tick and input synchroniser
    // ----------------------------------------------------------------

    logic [31:0] acc_reg, acc_next;
    logic        tick_reg, tick_next;
    logic        rxd_meta_reg, rxd_sync_reg;

    // Fractional divider: average 24 MHz enable from the fast clock
    always_comb begin
        acc_next  = acc_reg + ACC_STEP;
        tick_next = 1'b0;
        if (acc_next >= ACC_WRAP) begin
            acc_next  = acc_next - ACC_WRAP;
            tick_next = 1'b1;
        end
    end

    // Two stages; only the second is read, line taken non-inverted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg      <= 32'h0;
            tick_reg     <= 1'b0;
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
        end else begin
            acc_reg      <= acc_next;
            tick_reg     <= tick_next;
            rxd_meta_reg <= serial_in_line_i;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------

    ucr_rx_state_t rx_st_reg, rx_st_next;
    logic [11:0]   rx_cnt_reg, rx_cnt_next;
    logic [2:0]    rx_bit_reg, rx_bit_next;
    logic [7:0]    rx_sh_reg, rx_sh_next;
    logic          rx_par_reg, rx_par_next;
    logic          rx_fin;
    ucr_rx_frame_t rx_frm;
    logic          run_reg;

    // Samples mid-bit; a start edge is only honoured once running
    always_comb begin
        rx_st_next  = rx_st_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_bit_next = rx_bit_reg;
        rx_sh_next  = rx_sh_reg;
        rx_par_next = rx_par_reg;
        rx_fin      = 1'b0;
        rx_frm      = '{data: rx_sh_reg, perr: 1'b0, ferr: 1'b0};
        if (tick_reg) begin
            rx_cnt_next = rx_cnt_reg + 12'h1;
            case (rx_st_reg)
                RX_IDLE: begin
                    rx_cnt_next = 12'h0;
                    if (run_reg && !rxd_sync_reg) begin
                        rx_st_next = RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_reg == TICK_HALF) begin
                        rx_cnt_next = 12'h0;
                        rx_bit_next = 3'h0;
                        rx_par_next = 1'b0;
                        rx_st_next  = rxd_sync_reg ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_reg == TICK_LAST) begin
                        rx_cnt_next = 12'h0;
                        rx_sh_next  = {rxd_sync_reg, rx_sh_reg[7:1]};
                        rx_par_next = rx_par_reg ^ rxd_sync_reg;
                        rx_bit_next = rx_bit_reg + 3'h1;
                        if (rx_bit_reg == BIT_LAST) begin
                            rx_st_next = RX_PAR;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_cnt_reg == TICK_LAST) begin
                        rx_cnt_next = 12'h0;
                        rx_par_next = rx_par_reg ^ rxd_sync_reg;
                        rx_st_next  = RX_STOP;
                    end
                end
                default: begin
                    if (rx_cnt_reg == TICK_LAST) begin
                        rx_fin      = 1'b1;
                        rx_frm.perr = rx_par_reg;
                        rx_frm.ferr = !rxd_sync_reg;
                        rx_st_next  = RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_st_reg  <= RX_IDLE;
            rx_cnt_reg <= 12'h0;
            rx_bit_reg <= 3'h0;
            rx_sh_reg  <= 8'h00;
            rx_par_reg <= 1'b0;
        end else begin
            rx_st_reg  <= rx_st_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_bit_reg <= rx_bit_next;
            rx_sh_reg  <= rx_sh_next;
            rx_par_reg <= rx_par_next;
        end
    end

    // ----------------------------------------------------------------
    // Reply sequencer and transmitter
    // ----------------------------------------------------------------

    ucr_tx_state_t tx_st_reg, tx_st_next;
    ucr_reply_t    kind_reg, kind_next;
    ucr_rx_frame_t buf_reg, buf_next;
    logic          full_reg, full_next;
    logic          ovr_reg, ovr_next;
    logic [1:0]    idx_reg, idx_next;
    logic [11:0]   tx_cnt_reg, tx_cnt_next;
    logic [2:0]    tx_bit_reg, tx_bit_next;
    logic [7:0]    tx_sh_reg, tx_sh_next;
    logic          tx_par_reg, tx_par_next;
    logic          txd_reg, txd_next;
    logic          rxe_reg, rxe_next, rxd_reg, rxd_next, txe_reg, txe_next;
    logic [1:0]    lvl_reg, lvl_next;
    logic          hiprio_reg;
    logic [7:0]    cur_byte;  // Reply byte now being framed
    logic          ovr_now;   // Frame this cycle found the buffer still full

    // Single-entry holding buffer; a frame landing on a full one is an overrun
    always_comb begin
        tx_st_next  = tx_st_reg;
        kind_next   = kind_reg;
        buf_next    = buf_reg;
        full_next   = full_reg;
        ovr_next    = ovr_reg;
        idx_next    = idx_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_bit_next = tx_bit_reg;
        tx_sh_next  = tx_sh_reg;
        tx_par_next = tx_par_reg;
        txd_next    = txd_reg;
        txe_next    = 1'b0;
        ovr_now     = 1'b0;
        cur_byte    = reply_byte(kind_reg, idx_reg);
        // Pick a reply; overrun first, error replies suppress classification
        if (tx_st_reg == TX_IDLE && (ovr_reg || full_reg)) begin
            if (ovr_reg) begin
                kind_next = REP_OE;
                ovr_next  = 1'b0;
            end else begin
                full_next = 1'b0;
                if (buf_reg.ferr) begin
                    kind_next = REP_FE;
                end else if (buf_reg.perr) begin
                    kind_next = REP_PE;
                end else if (buf_reg.data == `UCR_CH_UPPER_T) begin
                    kind_next = REP_UPPER;
                end else if (buf_reg.data == `UCR_CH_LOWER_T) begin
                    kind_next = REP_LOWER;
                end else begin
                    kind_next = REP_OTHER;
                end
            end
            idx_next    = 2'h0;
            tx_cnt_next = 12'h0;
            tx_st_next  = TX_START;
            txd_next    = 1'b0;
        end else if (tick_reg && tx_st_reg != TX_IDLE) begin
            tx_cnt_next = tx_cnt_reg + 12'h1;
            if (tx_cnt_reg == TICK_LAST) begin
                tx_cnt_next = 12'h0;
                case (tx_st_reg)
                    TX_START: begin
                        tx_bit_next = 3'h1;
                        tx_sh_next  = cur_byte >> 1;
                        txd_next    = cur_byte[0];
                        tx_par_next = ^cur_byte;
                        tx_st_next  = TX_DATA;
                    end
                    TX_DATA: begin
                        if (tx_bit_reg == 3'h0) begin
                            txd_next   = tx_par_reg;
                            tx_st_next = TX_PAR;
                        end else begin
                            txd_next    = tx_sh_reg[0];
                            tx_sh_next  = tx_sh_reg >> 1;
                            tx_bit_next = tx_bit_reg + 3'h1;
                        end
                    end
                    TX_PAR: begin
                        txd_next   = 1'b1;
                        tx_st_next = TX_STOP;
                    end
                    default: begin
                        txe_next = 1'b1;
                        idx_next = idx_reg + 2'h1;
                        if (idx_reg == `UCR_LAST_IDX) begin
                            tx_st_next = TX_IDLE;
                        end else begin
                            txd_next   = 1'b0;
                            tx_st_next = TX_START;
                        end
                    end
                endcase
            end
        end
        // New frame lands after the consume, so a set here is never lost
        if (rx_fin) begin
            if (full_next) begin
                ovr_next = 1'b1;
                ovr_now  = 1'b1;
            end else begin
                buf_next  = rx_frm;
                full_next = 1'b1;
            end
        end
        // Events and the level of the most urgent one this cycle
        // Overrun judged after the consume, matching what the buffer keeps
        rxd_next = rx_fin && !rx_frm.perr && !rx_frm.ferr && !ovr_now;
        rxe_next = rx_fin && (rx_frm.perr || rx_frm.ferr || ovr_now);
        if (rxd_next || rxe_next) begin
            lvl_next = hiprio_reg ? `UCR_LVL_ONE : `UCR_LVL_TWO;
        end else if (txe_next) begin
            lvl_next = `UCR_LVL_TX;
        end else begin
            lvl_next = `UCR_LVL_NONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st_reg  <= TX_IDLE;
            kind_reg   <= REP_OTHER;
            buf_reg    <= '0;
            full_reg   <= 1'b0;
            ovr_reg    <= 1'b0;
            idx_reg    <= 2'h0;
            tx_cnt_reg <= 12'h0;
            tx_bit_reg <= 3'h0;
            tx_sh_reg  <= 8'h00;
            tx_par_reg <= 1'b0;
            txd_reg    <= 1'b1;
            rxd_reg    <= 1'b0;
            rxe_reg    <= 1'b0;
            txe_reg    <= 1'b0;
            lvl_reg    <= `UCR_LVL_NONE;
        end else begin
            tx_st_reg  <= tx_st_next;
            kind_reg   <= kind_next;
            buf_reg    <= buf_next;
            full_reg   <= full_next;
            ovr_reg    <= ovr_next;
            idx_reg    <= idx_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_bit_reg <= tx_bit_next;
            tx_sh_reg  <= tx_sh_next;
            tx_par_reg <= tx_par_next;
            txd_reg    <= txd_next;
            rxd_reg    <= rxd_next;
            rxe_reg    <= rxe_next;
            txe_reg    <= txe_next;
            lvl_reg    <= lvl_next;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone register file
    // ----------------------------------------------------------------

    logic        run_next, hiprio_next, ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic [2:0]  err_reg, err_next;
    logic        wr_en;

    // Answers one cycle after the request; unmapped reads return zero
    always_comb begin
        wr_en       = cyc_i && stb_i && we_i && !ack_reg && sel_i[0];
        ack_next    = cyc_i && stb_i && !ack_reg;
        run_next    = run_reg;
        hiprio_next = hiprio_reg;
        dat_next    = 32'h0;
        err_next    = err_reg;
        if (rx_fin) begin
            err_next = {ovr_now, rx_frm.ferr, rx_frm.perr};
        end
        if (wr_en && adr_i == `UCR_OFS_CTRL) begin
            run_next    = dat_i[`UCR_CTRL_START];
            hiprio_next = dat_i[`UCR_CTRL_HIPRIO];
        end
        if (adr_i == `UCR_OFS_CTRL) begin
            dat_next[`UCR_CTRL_START]  = run_reg;
            dat_next[`UCR_CTRL_HIPRIO] = hiprio_reg;
        end else if (adr_i == `UCR_OFS_STATUS) begin
            dat_next[`UCR_ST_RUN]  = run_reg;
            dat_next[`UCR_ST_BUSY] = tx_st_reg != TX_IDLE;
            dat_next[`UCR_ST_FULL] = full_reg;
            dat_next[`UCR_ST_OE:`UCR_ST_PE] = err_reg;
        end else if (adr_i == `UCR_OFS_RXDATA) begin
            dat_next[7:0] = buf_reg.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg    <= 1'b0;
            hiprio_reg <= 1'b0;
            ack_reg    <= 1'b0;
            dat_reg    <= 32'h0;
            err_reg    <= 3'h0;
        end else begin
            run_reg    <= run_next;
            hiprio_reg <= hiprio_next;
            ack_reg    <= ack_next;
            dat_reg    <= dat_next;
            err_reg    <= err_next;
        end
    end

    // Outputs straight from flip-flops
    assign serial_out_line_o = txd_reg;
    assign dat_o             = dat_reg;
    assign ack_o             = ack_reg;
    assign rx_done_event_o   = rxd_reg;
    assign rx_error_event_o  = rxe_reg;
    assign tx_done_event_o   = txe_reg;
    assign event_level_o     = lvl_reg;

endmodule

//--- tb/ucr_monitor.sv
// Purpose : Port checker for the serial responder
// Assumes : Bound to ucr_responder, one clock domain
// Notes   : Watches the bus request inputs and the design outputs
`timescale 1ns/1ps
module ucr_monitor #(
    parameter int unsigned CLK_HZ    = 1,
    parameter int unsigned PERIPH_HZ = 1,
    parameter int unsigned BIT_TICKS = 8
) (
    // Clock, reset, bus
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    // Serial line and events
    input wire logic       serial_out_line_o,
    input wire logic       rx_done_event_o,
    input wire logic       tx_done_event_o,
    input wire logic       rx_error_event_o,
    input wire logic [1:0] event_level_o
);
    localparam int unsigned BITC = (BIT_TICKS * 64'(CLK_HZ)) / PERIPH_HZ;
    logic [19:0] hi_reg;
    logic [19:0] hi_next;
    logic        rx_ev;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Idle run length; saturates so a long idle never looks busy
    always_comb begin
        hi_next = serial_out_line_o ? hi_reg + 20'((&hi_reg) ? 0 : 1) : 20'h00000;
        rx_ev   = rx_done_event_o || rx_error_event_o;
    end
    always_ff @(posedge clk_i) begin
        hi_reg <= rst_i ? 20'h00000 : hi_next;
    end
    ack_answer_a: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o) else $error("no bus answer");
    tx_level_a: assert property ((tx_done_event_o && !rx_ev) |-> event_level_o == 2'h3) else $error("tx level");
    rx_level_a: assert property (rx_ev |-> event_level_o inside {2'h1, 2'h2}) else $error("rx level");
    one_kind_a: assert property (!(rx_done_event_o && rx_error_event_o)) else $error("both rx events");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> serial_out_line_o && !rx_ev) else $error("reset");
    stop_high_a: assert property (tx_done_event_o |-> $past(serial_out_line_o, 2)) else $error("stop low");
    reply_start_a: assert property ((rx_ev && hi_reg > 10 * BITC) |-> ##[2:3] !serial_out_line_o) else $error("late");
    tx_spacing_a: assert property (tx_done_event_o |=> !tx_done_event_o [*8]) else $error("tx spacing");
endmodule
bind ucr_responder ucr_monitor #(.CLK_HZ(CLK_HZ), .PERIPH_HZ(PERIPH_HZ), .BIT_TICKS(BIT_TICKS)) u_ucr_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .serial_out_line_o(serial_out_line_o), .rx_done_event_o(rx_done_event_o),
    .tx_done_event_o(tx_done_event_o), .rx_error_event_o(rx_error_event_o), .event_level_o(event_level_o));

//--- tb/ucr_far_end.sv
// Purpose : Far-side serial device model
// Assumes : One bit lasts BT clocks
// Notes   : Sends frames, collects reply bytes in rxq
`timescale 1ns/1ps
module ucr_far_end #(
    parameter int BT = 8
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    logic [7:0]  rxq[$];
    logic        err;
    logic [10:0] f;
    initial begin
        line_o = 1'b1;
        err    = 1'b0;
    end
    // Frame out: start, data LSB first, even parity, stop
    task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
        logic [10:0] fo;
        fo = {~bad_stop, ^b ^ bad_par, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_i) line_o <= fo[i];
            repeat (BT - 1) @(posedge clk_i);
        end
        @(posedge clk_i) line_o <= 1'b1;
    endtask
    // Frame in, sampled mid-bit; no wait after stop so back-to-back works
    always begin
        @(negedge line_i);
        repeat (BT / 2) @(negedge clk_i);
        for (int i = 0; i < 11; i++) begin
            f[i] = line_i;
            if (i < 10) repeat (BT) @(negedge clk_i);
        end
        if (f[0] !== 1'b0 || f[10] !== 1'b1 || ^f[9:1] !== 1'b0) err = 1'b1;
        rxq.push_back(f[8:1]);
    end
endmodule

//--- tb/tb_ucr_responder.sv
// Purpose : Self-checking bench for the serial responder
// Assumes : One peripheral tick per clock, 8 ticks a bit
// Notes   : Replies are collected by the far-side model
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_ucr_responder;
    import ucr_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, tx_ev, rx_ev, er_ev, line_in, line_out;
    logic [3:0]  adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [1:0]  lvl_o, lvl;
    int          mismatches = 0, compares = 0, n_rx = 0, n_tx = 0, n_er = 0;
    always #2 clk_i = ~clk_i;
    ucr_responder #(.PERIPH_HZ(250000000), .BIT_TICKS(8)) u_ucr_responder (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .serial_in_line_i(line_in), .serial_out_line_o(line_out), .rx_done_event_o(rx_ev),
        .tx_done_event_o(tx_ev), .rx_error_event_o(er_ev), .event_level_o(lvl_o));
    ucr_far_end #(.BT(8)) u_ucr_far_end (.clk_i(clk_i), .line_i(line_out), .line_o(line_in));
    // Event tally and level of the latest rx event
    always @(posedge clk_i) begin
        n_rx <= n_rx + int'(rx_ev);
        n_tx <= n_tx + int'(tx_ev);
        n_er <= n_er + int'(er_ev);
        if (rx_ev || er_ev) lvl <= lvl_o;
    end
    // Classic single bus cycle; waits for ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i) {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
        q = dat_o;
        if (n >= 50) mismatches++;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    // One character in, four reply bytes and event counts out
    task automatic one(input logic [7:0] c, input logic bp, input logic bs, input logic [31:0] exp,
                       input int drx, input int der);
        int r0, e0, t0;
        {r0, e0, t0} = {n_rx, n_er, n_tx};
        u_ucr_far_end.send(c, bp, bs);
        expect4(exp);
        repeat (12) @(posedge clk_i);
        `CHK(n_rx - r0, drx)
        `CHK(n_er - e0, der)
        `CHK(n_tx - t0, 4)
    endtask
    task automatic expect4(input logic [31:0] exp);
        int n;
        logic [7:0] b;
        n = 0;
        while (u_ucr_far_end.rxq.size() < 4 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        for (int i = 3; i >= 0; i--) begin
            b = (u_ucr_far_end.rxq.size() > 0) ? u_ucr_far_end.rxq.pop_front() : 8'hXX;
            `CHK(b, exp[i*8 +: 8])
        end
    endtask
    task automatic t_ignore();
        u_ucr_far_end.send(8'h54, 1'b0, 1'b0);
        repeat (200) @(posedge clk_i);
        `CHK(u_ucr_far_end.rxq.size() + n_rx + n_er, 0)
        $display("t_ignore done");
    endtask
    task automatic t_start();
        wb(1'b1, 4'h0, 32'h1);
        wb(1'b0, 4'h4, 32'h0);
        `CHK(q[0], 1'b1)
        wb(1'b0, 4'hC, 32'h0);
        `CHK(q, 32'h0)
        $display("t_start done");
    endtask
    task automatic t_chars();
        one(8'h54, 1'b0, 1'b0, 32'h4F4B0D0A, 1, 0);
        one(8'h74, 1'b0, 1'b0, 32'h6F6B0D0A, 1, 0);
        one(8'hFF, 1'b0, 1'b0, 32'h55430D0A, 1, 0);
        `CHK(lvl, 2'h2)
        $display("t_chars done");
    endtask
    task automatic t_errs();
        one(8'h54, 1'b1, 1'b0, 32'h50450D0A, 0, 1);
        one(8'h74, 1'b0, 1'b1, 32'h46450D0A, 0, 1);
        wb(1'b0, 4'h4, 32'h0);
        `CHK(q[9], 1'b1)
        $display("t_errs done");
    endtask
    task automatic t_overrun();
        wb(1'b1, 4'h0, 32'h3);
        u_ucr_far_end.send(8'h54, 1'b0, 1'b0);
        u_ucr_far_end.send(8'h41, 1'b0, 1'b0);
        u_ucr_far_end.send(8'h42, 1'b0, 1'b0);
        expect4(32'h4F4B0D0A);
        expect4(32'h4F450D0A);
        expect4(32'h55430D0A);
        `CHK(lvl, 2'h1)
        `CHK(u_ucr_far_end.err, 1'b0)
        $display("t_overrun done");
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence after a three-cycle reset
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ignore();
        t_start();
        t_chars();
        t_errs();
        t_overrun();
        complete_run();
    end
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        complete_run();
    end
endmodule
